// file: verilog/psdr_defs.vh
// Purpose: Constants for the processor status and debug register bank
// Assumes: Register numbers are word indices on the processor status port
// Notes:   Field positions and reset values for the design; the bench uses its own literals
`ifndef PSDR_DEFS_VH
`define PSDR_DEFS_VH

// ----------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------
`define PSDR_OSC_CTRL          8'h06
`define PSDR_TILE_CELL_OSC     8'h07
`define PSDR_TILE_WIRE_OSC     8'h08
`define PSDR_PERIPH_CELL_OSC   8'h09
`define PSDR_PERIPH_WIRE_OSC   8'h0A
`define PSDR_RAM_CAPACITY      8'h0C
`define PSDR_DBG_SAVED_STATUS  8'h10
`define PSDR_DBG_SAVED_PC      8'h11
`define PSDR_DBG_SAVED_SP      8'h12
`define PSDR_DBG_THREAD_SEL    8'h13
`define PSDR_DBG_REG_SEL       8'h14
`define PSDR_DBG_IRQ_CAUSE     8'h15

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define PSDR_OSC_CNT_W         16
`define PSDR_OSC_CORE_EN_BIT   1
`define PSDR_OSC_PERIPH_EN_BIT 0
`define PSDR_SSR_W             11
`define PSDR_SSR_WR_MASK       11'h6DF
`define PSDR_SSR_ISSUE_BIT     8
`define PSDR_THREAD_W          8
`define PSDR_REGSEL_W          5
`define PSDR_CAUSE_W           3
`define PSDR_BPIDX_W           2
`define PSDR_BP_COUNT          4
`define PSDR_CAUSE_THREAD_LSB  8
`define PSDR_CAUSE_BPIDX_LSB   16

// ----------------------------------------------------------------
// Cause codes and reset values
// ----------------------------------------------------------------
`define PSDR_CAUSE_NONE        3'h0
`define PSDR_CAUSE_HOST        3'h1
`define PSDR_CAUSE_DEBUG_CALL_INSTR       3'h2
`define PSDR_CAUSE_IBREAK      3'h3
`define PSDR_CAUSE_DWATCH      3'h4
`define PSDR_CAUSE_RWATCH      3'h5
`define PSDR_RAM_BYTES_DEF     32'h0002_0000

`endif

// file: verilog/psdr_regs.v
// Purpose: Processor status and debug register bank for one tile
// Assumes: One core clock; registers reached over the processor status port
// Notes:   Ring oscillators are modelled as gated counters on their own enables
//
// Function
// - Four oscillator count registers at 0x07-0x0A
// - Counts sit in 15:0, upper bits zero
// - System reset leaves oscillator counts untouched
// - RAM byte size in bits 31:2
// - Capture saved status word on debugger entry
// - Status bits 0,1: events, interrupts enabled
// - Status bits 2,3,4: enabling, handler, kernel
// - Status bits 6,7: paused, fast mode
// - Bit 8 read-only issue mode; 9 and 10 writable
// - Capture saved program counter, debugger read/write
// - Capture saved stack pointer, debugger read/write
// - Thread select field drives register-read thread
// - Register index field drives register-read selection
// - Three-bit cause field, resets to zero
// - Cause codes one to five by source
// - Thread field, zero for host requests
// - Breakpoint index, zero for host and debug-call
// - Lowest-numbered simultaneous breakpoint is reported
// - Oscillator enables in control bits 1 and 0
`timescale 1ns/1ps
`include "psdr_defs.vh"

module psdr_regs
#(
  parameter [31:0] RAM_BYTES = `PSDR_RAM_BYTES_DEF
)
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        ps_wr,
  input  wire        ps_rd,
  input  wire [7:0]  ps_addr,
  input  wire [31:0] ps_wdata,
  output reg  [31:0] ps_rdata,
  input  wire        dbg_entry,
  input  wire [2:0]  dbg_cause,
  input  wire [7:0]  dbg_thread,
  input  wire [3:0]  dbg_bp_hits,
  input  wire [10:0] saved_status_word,
  input  wire [31:0] saved_program_counter,
  input  wire [31:0] saved_stack_pointer,
  input  wire        cur_issue_mode,
  output wire [7:0]  debug_thread_reg_read_thread,
  output wire [4:0]  debug_thread_reg_read_index,
  output wire        core_osc_en,
  output wire        periph_osc_en
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One strobe per writable register keeps every write compare in one place
  wire        wr_osc_ctrl;
  wire        wr_ssr;
  wire        wr_spc;
  wire        wr_ssp;
  wire        wr_thread_sel;
  wire        wr_reg_sel;
  wire        wr_cause;

  assign wr_osc_ctrl   = ps_wr && (ps_addr == `PSDR_OSC_CTRL);
  assign wr_ssr        = ps_wr && (ps_addr == `PSDR_DBG_SAVED_STATUS);
  assign wr_spc        = ps_wr && (ps_addr == `PSDR_DBG_SAVED_PC);
  assign wr_ssp        = ps_wr && (ps_addr == `PSDR_DBG_SAVED_SP);
  assign wr_thread_sel = ps_wr && (ps_addr == `PSDR_DBG_THREAD_SEL);
  assign wr_reg_sel    = ps_wr && (ps_addr == `PSDR_DBG_REG_SEL);
  assign wr_cause      = ps_wr && (ps_addr == `PSDR_DBG_IRQ_CAUSE);

  // ----------------------------------------------------------------
  // Oscillator control and counters
  // ----------------------------------------------------------------
  localparam OSC_NUM = 4;

  reg  [1:0]  osc_ctrl_reg;
  reg  [1:0]  osc_ctrl_next;
  wire [3:0]  osc_run;
  wire [63:0] osc_cnt_flat;

  always @*
  begin
    osc_ctrl_next = osc_ctrl_reg;
    if (wr_osc_ctrl)
      osc_ctrl_next = ps_wdata[1:0];
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      osc_ctrl_reg <= 2'h0;
    else
      osc_ctrl_reg <= osc_ctrl_next;
  end

  assign core_osc_en   = osc_ctrl_reg[`PSDR_OSC_CORE_EN_BIT];
  assign periph_osc_en = osc_ctrl_reg[`PSDR_OSC_PERIPH_EN_BIT];

  // Tile counters follow the core enable, peripheral counters their own
  assign osc_run = {periph_osc_en, periph_osc_en, core_osc_en, core_osc_en};

  // Counters sit outside the reset net so counts survive a system reset.
  // A count only holds still once its enable is low, hence the wait
  // software must leave before reading it.
  genvar gi;
  generate
    for (gi = 0; gi < OSC_NUM; gi = gi + 1)
    begin : g_osc
      reg  [15:0] cnt_reg;
      wire [15:0] cnt_next;

      assign cnt_next = osc_run[gi] ? (cnt_reg + 16'h0001) : cnt_reg;

      always @(posedge core_clk)
      begin
        cnt_reg <= cnt_next;
      end

      assign osc_cnt_flat[gi*16 +: 16] = cnt_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Breakpoint priority
  // ----------------------------------------------------------------
  reg  [1:0]  bp_lowest;
  wire        no_index;

  // Lowest set hit wins
  always @*
  begin
    bp_lowest = 2'h0;
    if (dbg_bp_hits[0])
      bp_lowest = 2'h0;
    else if (dbg_bp_hits[1])
      bp_lowest = 2'h1;
    else if (dbg_bp_hits[2])
      bp_lowest = 2'h2;
    else if (dbg_bp_hits[3])
      bp_lowest = 2'h3;
  end

  // Host and debug-call entries carry no breakpoint number
  assign no_index = (dbg_cause == `PSDR_CAUSE_HOST) || (dbg_cause == `PSDR_CAUSE_DEBUG_CALL_INSTR);

  // ----------------------------------------------------------------
  // Debug capture registers
  // ----------------------------------------------------------------
  reg  [10:0] ssr_reg;
  reg  [10:0] ssr_next;
  reg  [31:0] spc_reg;
  reg  [31:0] spc_next;
  reg  [31:0] ssp_reg;
  reg  [31:0] ssp_next;
  reg  [7:0]  thread_sel_reg;
  reg  [7:0]  thread_sel_next;
  reg  [4:0]  reg_sel_reg;
  reg  [4:0]  reg_sel_next;
  reg  [2:0]  cause_reg;
  reg  [2:0]  cause_next;
  reg  [7:0]  cause_thread_reg;
  reg  [7:0]  cause_thread_next;
  reg  [1:0]  bp_idx_reg;
  reg  [1:0]  bp_idx_next;

  always @*
  begin
    ssr_next          = ssr_reg;
    spc_next          = spc_reg;
    ssp_next          = ssp_reg;
    thread_sel_next   = thread_sel_reg;
    reg_sel_next      = reg_sel_reg;
    cause_next        = cause_reg;
    cause_thread_next = cause_thread_reg;
    bp_idx_next       = bp_idx_reg;
    if (dbg_entry)
    begin
      // Capture beats a same-cycle debugger write
      ssr_next          = saved_status_word & `PSDR_SSR_WR_MASK;
      spc_next          = saved_program_counter;
      ssp_next          = saved_stack_pointer;
      cause_next        = dbg_cause;
      cause_thread_next = (dbg_cause == `PSDR_CAUSE_HOST) ? 8'h00 : dbg_thread;
      bp_idx_next       = no_index ? 2'h0 : bp_lowest;
    end
    else
    begin
      if (wr_ssr)
        ssr_next = ps_wdata[10:0] & `PSDR_SSR_WR_MASK;
      if (wr_spc)
        spc_next = ps_wdata;
      if (wr_ssp)
        ssp_next = ps_wdata;
      if (wr_cause)
      begin
        cause_next        = ps_wdata[2:0];
        cause_thread_next = ps_wdata[15:8];
        bp_idx_next       = ps_wdata[17:16];
      end
    end
    // Read selects are never captured, so their writes always land
    if (wr_thread_sel)
      thread_sel_next = ps_wdata[7:0];
    if (wr_reg_sel)
      reg_sel_next = ps_wdata[4:0];
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ssr_reg          <= 11'h000;
      spc_reg          <= 32'h0000_0000;
      ssp_reg          <= 32'h0000_0000;
      thread_sel_reg   <= 8'h00;
      reg_sel_reg      <= 5'h00;
      cause_reg        <= `PSDR_CAUSE_NONE;
      cause_thread_reg <= 8'h00;
      bp_idx_reg       <= 2'h0;
    end
    else
    begin
      ssr_reg          <= ssr_next;
      spc_reg          <= spc_next;
      ssp_reg          <= ssp_next;
      thread_sel_reg   <= thread_sel_next;
      reg_sel_reg      <= reg_sel_next;
      cause_reg        <= cause_next;
      cause_thread_reg <= cause_thread_next;
      bp_idx_reg       <= bp_idx_next;
    end
  end

  assign debug_thread_reg_read_thread = thread_sel_reg;
  assign debug_thread_reg_read_index  = reg_sel_reg;

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  // Reserved positions of control, RAM size, status and cause are tied to zero here; count and select reads pad in the read mux
  wire [31:0] osc_ctrl_view;
  wire [31:0] ram_view;
  wire [31:0] ssr_view;
  wire [31:0] cause_view;

  assign osc_ctrl_view = {30'h0000_0000, osc_ctrl_reg};
  assign ram_view      = {RAM_BYTES[31:2], 2'h0};
  assign ssr_view      = {21'h00_0000, ssr_reg[10:9], cur_issue_mode, ssr_reg[7:0]};
  assign cause_view    = {14'h0000, bp_idx_reg, cause_thread_reg, 5'h00, cause_reg};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  reg  [31:0] rdata_next;

  // Read data holds between reads; unmapped numbers read zero
  always @*
  begin
    rdata_next = ps_rdata;
    if (ps_rd)
    begin
      if (ps_addr == `PSDR_OSC_CTRL)
        rdata_next = osc_ctrl_view;
      else if (ps_addr == `PSDR_TILE_CELL_OSC)
        rdata_next = {16'h0000, osc_cnt_flat[15:0]};
      else if (ps_addr == `PSDR_TILE_WIRE_OSC)
        rdata_next = {16'h0000, osc_cnt_flat[31:16]};
      else if (ps_addr == `PSDR_PERIPH_CELL_OSC)
        rdata_next = {16'h0000, osc_cnt_flat[47:32]};
      else if (ps_addr == `PSDR_PERIPH_WIRE_OSC)
        rdata_next = {16'h0000, osc_cnt_flat[63:48]};
      else if (ps_addr == `PSDR_RAM_CAPACITY)
        rdata_next = ram_view;
      else if (ps_addr == `PSDR_DBG_SAVED_STATUS)
        rdata_next = ssr_view;
      else if (ps_addr == `PSDR_DBG_SAVED_PC)
        rdata_next = spc_reg;
      else if (ps_addr == `PSDR_DBG_SAVED_SP)
        rdata_next = ssp_reg;
      else if (ps_addr == `PSDR_DBG_THREAD_SEL)
        rdata_next = {24'h00_0000, thread_sel_reg};
      else if (ps_addr == `PSDR_DBG_REG_SEL)
        rdata_next = {27'h000_0000, reg_sel_reg};
      else if (ps_addr == `PSDR_DBG_IRQ_CAUSE)
        rdata_next = cause_view;
      else
        rdata_next = 32'h0000_0000;
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ps_rdata <= 32'h0000_0000;
    else
      ps_rdata <= rdata_next;
  end

endmodule

// file: verif/psdr_regs_props.sv
// Purpose: Port assertions for the status and debug bank
// Assumes: Read data lands one edge after the read strobe
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module psdr_regs_props
#(
  parameter [31:0] RAM_BYTES = 32'h0002_0000
)
(
  input wire        core_clk,
  input wire        rst,
  input wire        ps_wr,
  input wire        ps_rd,
  input wire [7:0]  ps_addr,
  input wire [31:0] ps_wdata,
  input wire [31:0] ps_rdata,
  input wire        dbg_entry,
  input wire [2:0]  dbg_cause,
  input wire        cur_issue_mode,
  input wire [7:0]  debug_thread_reg_read_thread,
  input wire [4:0]  debug_thread_reg_read_index,
  input wire        core_osc_en,
  input wire        periph_osc_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_ram; ps_rd && ps_addr == 8'h0C |=> ps_rdata == {RAM_BYTES[31:2], 2'b00}; endproperty
  a_ram: assert property (p_ram) else $error("ram size");
  property p_osc;
    ps_rd && ps_addr inside {[8'h07:8'h0A]} |=> ps_rdata[31:16] == 16'h0000;
  endproperty
  a_osc: assert property (p_osc) else $error("count top");
  property p_ssr; ps_rd && ps_addr == 8'h10 |=> ps_rdata[8] == $past(cur_issue_mode); endproperty
  a_ssr: assert property (p_ssr) else $error("issue bit");
  property p_thr;
    ps_wr && ps_addr == 8'h13 |=> debug_thread_reg_read_thread == $past(ps_wdata[7:0]);
  endproperty
  a_thr: assert property (p_thr) else $error("thread sel");
  property p_idx;
    ps_wr && ps_addr == 8'h14 |=> debug_thread_reg_read_index == $past(ps_wdata[4:0]);
  endproperty
  a_idx: assert property (p_idx) else $error("reg sel");
  property p_en; ps_wr && ps_addr == 8'h06 |=> {core_osc_en, periph_osc_en} == $past(ps_wdata[1:0]); endproperty
  a_en: assert property (p_en) else $error("osc enable");
  property p_cause; dbg_entry ##1 ps_rd && ps_addr == 8'h15 |=> ps_rdata[2:0] == $past(dbg_cause, 2); endproperty
  a_cause: assert property (p_cause) else $error("cause");
  property p_host;
    dbg_entry && dbg_cause == 3'h1 ##1 ps_rd && ps_addr == 8'h15 |=> ps_rdata[17:8] == 10'h000;
  endproperty
  a_host: assert property (p_host) else $error("host fields");
endmodule

// file: verif/psdr_dbg_host.sv
// Purpose: Debugger and core model driving the bank
// Assumes: Inputs change at the falling edge
// Notes:   Each expected read is noted in exp_q as mask and value
`timescale 1ns/1ps
module psdr_dbg_host
(
  input  wire        core_clk,
  output reg         ps_wr,
  output reg         ps_rd,
  output reg  [7:0]  ps_addr,
  output reg  [31:0] ps_wdata,
  output reg         dbg_entry,
  output reg  [2:0]  dbg_cause,
  output reg  [7:0]  dbg_thread,
  output reg  [3:0]  dbg_bp_hits,
  output reg  [10:0] saved_status_word,
  output reg  [31:0] saved_program_counter,
  output reg  [31:0] saved_stack_pointer,
  output reg         cur_issue_mode
);
  logic [63:0] exp_q[$];
  integer      seed = 45495;
  reg   [31:0] d;
  initial
  begin
    {ps_wr, ps_rd, ps_addr, ps_wdata, dbg_entry, dbg_cause, dbg_thread, cur_issue_mode} = 0;
    {dbg_bp_hits, saved_status_word, saved_program_counter, saved_stack_pointer} = 0;
  end
  task wr(input [7:0] a, input [31:0] v);
  begin
    @(negedge core_clk);
    {ps_wr, ps_addr, ps_wdata} = {1'b1, a, v};
    @(negedge core_clk);
    ps_wr = 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
  begin
    @(negedge core_clk);
    {ps_rd, ps_addr} = {1'b1, a};
    cur_issue_mode = $random(seed);
    if (a == 8'h10) e[8] = cur_issue_mode;
    exp_q.push_back({m, e & m});
    @(negedge core_clk);
    ps_rd = 1'b0;
  end
  endtask
  task wrrd(input [7:0] a, input [31:0] keep);
  begin
    d = $random(seed);
    wr(a, d);
    rd(a, d & keep, 32'hFFFF_FFFF);
  end
  endtask
  task cap(input [2:0] c);
    reg [1:0]  ix;
    reg [31:0] p, s;
  begin
    d = $random(seed);
    d[14] = 1'b1;
    p = $random(seed);
    s = $random(seed);
    ix = d[11] ? 2'h0 : d[12] ? 2'h1 : d[13] ? 2'h2 : 2'h3;
    if (c < 3'h3) ix = 2'h0;
    @(negedge core_clk);
    {dbg_entry, dbg_cause, dbg_thread, dbg_bp_hits, saved_status_word} = {1'b1, c, d[22:0]};
    {saved_program_counter, saved_stack_pointer} = {p, s};
    @(negedge core_clk);
    {dbg_entry, ps_rd, ps_addr} = {2'b01, 8'h15};
    // Inverted inputs show the capture is a sample, not a pass-through
    {saved_status_word, saved_program_counter, saved_stack_pointer} = ~{d[10:0], p, s};
    exp_q.push_back({32'hFFFF_FFFF, 14'h0, ix, (c == 3'h1) ? 8'h00 : d[22:15], 5'h0, c});
    @(negedge core_clk);
    ps_rd = 1'b0;
    rd(8'h11, p, 32'hFFFF_FFFF);
    rd(8'h12, s, 32'hFFFF_FFFF);
    rd(8'h10, {21'h0, d[10:0] & 11'h6DF}, 32'hFFFF_FFFF);
  end
  endtask
  task osc_stop;
  begin
    wr(8'h06, 32'h0000_0000);
    repeat (10) @(negedge core_clk);
  end
  endtask
endmodule

// file: verif/tb_psdr_regs.sv
// Purpose: Self-checking bench for the status and debug bank
// Assumes: Host model drives every bank input but clock and reset
// Notes:   Oscillator counts start unknown; only top bits compared
`timescale 1ns/1ps
module tb_psdr_regs;
  localparam [31:0] RAM_BYTES = 32'h0001_2347;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg         rd_seen = 1'b0;
  integer     err_total = 0;
  integer     num_checks = 0;
  integer     cycles = 0;
  integer     i;
  reg  [63:0] note;
  wire        ps_wr, ps_rd, dbg_entry, cur_issue_mode, core_osc_en, periph_osc_en;
  wire [7:0]  ps_addr, dbg_thread, debug_thread_reg_read_thread;
  wire [31:0] ps_wdata, ps_rdata, saved_program_counter, saved_stack_pointer;
  wire [2:0]  dbg_cause;
  wire [3:0]  dbg_bp_hits;
  wire [4:0]  debug_thread_reg_read_index;
  wire [10:0] saved_status_word;
  psdr_regs #(.RAM_BYTES(RAM_BYTES)) DUT
  (
    .core_clk(core_clk), .rst(rst), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .dbg_entry(dbg_entry), .dbg_cause(dbg_cause),
    .dbg_thread(dbg_thread), .dbg_bp_hits(dbg_bp_hits), .saved_status_word(saved_status_word),
    .saved_program_counter(saved_program_counter), .saved_stack_pointer(saved_stack_pointer),
    .cur_issue_mode(cur_issue_mode),
    .debug_thread_reg_read_thread(debug_thread_reg_read_thread),
    .debug_thread_reg_read_index(debug_thread_reg_read_index),
    .core_osc_en(core_osc_en), .periph_osc_en(periph_osc_en)
  );
  psdr_dbg_host host
  (
    .core_clk(core_clk), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr), .ps_wdata(ps_wdata),
    .dbg_entry(dbg_entry), .dbg_cause(dbg_cause), .dbg_thread(dbg_thread),
    .dbg_bp_hits(dbg_bp_hits), .saved_status_word(saved_status_word),
    .saved_program_counter(saved_program_counter), .saved_stack_pointer(saved_stack_pointer),
    .cur_issue_mode(cur_issue_mode)
  );
  always #20 core_clk = ~core_clk;
  task chk(input [31:0] seen, input [31:0] want);
  begin
    num_checks = num_checks + 1;
    if (seen !== want)
    begin
      err_total = err_total + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask
  task conclude;
  begin
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  always @(posedge core_clk) rd_seen <= ps_rd;
  always @(negedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      err_total = err_total + 1;
      conclude;
    end
    if (rd_seen && host.exp_q.size() > 0)
    begin
      note = host.exp_q.pop_front();
      chk(ps_rdata & note[63:32], note[31:0]);
    end
  end
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    host.rd(8'h0C, RAM_BYTES & 32'hFFFF_FFFC, 32'hFFFF_FFFF);
    host.rd(8'h15, 32'h0, 32'hFFFF_FFFF);
    host.wr(8'h0C, 32'h0000_0000);
    host.rd(8'h0C, RAM_BYTES & 32'hFFFF_FFFC, 32'hFFFF_FFFF);
    host.rd(8'h0B, 32'h0, 32'hFFFF_FFFF);
    host.wrrd(8'h11, 32'hFFFF_FFFF);
    host.wrrd(8'h12, 32'hFFFF_FFFF);
    host.wrrd(8'h13, 32'h0000_00FF);
    chk({24'h0, debug_thread_reg_read_thread}, host.d & 32'h0000_00FF);
    host.wrrd(8'h14, 32'h0000_001F);
    chk({27'h0, debug_thread_reg_read_index}, host.d & 32'h0000_001F);
    host.wrrd(8'h10, 32'h0000_06DF);
    host.wrrd(8'h15, 32'h0003_FF07);
    for (i = 0; i < 15; i = i + 1) host.cap(3'(i % 5 + 1));
    host.wr(8'h06, 32'h0000_0002);
    chk({30'h0, core_osc_en, periph_osc_en}, 32'h0000_0002);
    host.osc_stop;
    for (i = 7; i < 11; i = i + 1) host.rd(i[7:0], 32'h0, 32'hFFFF_0000);
    host.wr(8'h06, 32'h0000_0001);
    chk({30'h0, core_osc_en, periph_osc_en}, 32'h0000_0001);
    rst = 1'b1;
    @(negedge core_clk) rst = 1'b0;
    chk({17'h0, debug_thread_reg_read_thread, debug_thread_reg_read_index, core_osc_en,
         periph_osc_en}, 32'h0);
    host.rd(8'h15, 32'h0, 32'hFFFF_FFFF);
    repeat (2) @(negedge core_clk);
    conclude;
  end
endmodule
bind psdr_regs psdr_regs_props #(.RAM_BYTES(RAM_BYTES)) u_props
(
  .core_clk(core_clk), .rst(rst), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr),
  .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .dbg_entry(dbg_entry), .dbg_cause(dbg_cause),
  .cur_issue_mode(cur_issue_mode),
  .debug_thread_reg_read_thread(debug_thread_reg_read_thread),
  .debug_thread_reg_read_index(debug_thread_reg_read_index),
  .core_osc_en(core_osc_en), .periph_osc_en(periph_osc_en)
);
